// ---- core/pmsc_top.sv ----
`timescale 1ns/1ns
`include "pmsc_regs.svh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// - Detect event sets flag only when master-enabled.
// - Writing ack one clears detect flag.
// - Interrupt requested while flag and enable set.
// - Flag forces reset when reset and master enabled.
// - Stop enable keeps detection running during stop.
// - Master enable turns detection on, qualifies reset and stop enables.
// - Write-once bits take first write after reset.
// - Warning flag sets below trip, including after reset.
// - Warning ack clears only when condition gone.
// - Detect trip select picks low or high.
// - Warning trip select picks low or high.
// - Partial power-down recovery sets its flag.
// - Writing partial ack one clears its flag.
// - Write-once power-down enable gates stop modes.
// - Write-once select picks full or partial stop.
module pmsc_top (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        por_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        detect_low_in,
  input  wire logic        warning_low_in,
  input  wire logic        stop_active_in,
  input  wire logic        ppd_wake_in,
  input  wire logic        stop_req_in,
  output logic             detect_on_out,
  output logic             detect_trip_select_out,
  output logic             warning_trip_select_out,
  output logic             detect_irq_out,
  output logic             detect_reset_out,
  output logic [1:0]       stop_mode_out,
  output logic             irq_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin inputs pass three flip-flops; a change counts when stages two and three agree.

  logic [2:0] det_sync_r;
  logic [2:0] warn_sync_r;
  logic [2:0] wake_sync_r;
  logic       det_low_r;
  logic       warn_low_r;
  logic       wake_prev_r;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      det_sync_r  <= 3'h0;
      warn_sync_r <= 3'h0;
      wake_sync_r <= 3'h0;
    end else begin
      det_sync_r  <= {det_sync_r[1:0], detect_low_in};
      warn_sync_r <= {warn_sync_r[1:0], warning_low_in};
      wake_sync_r <= {wake_sync_r[1:0], ppd_wake_in};
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      det_low_r   <= 1'h0;
      warn_low_r  <= 1'h0;
      wake_prev_r <= 1'h0;
    end else begin
      if (det_sync_r[1] == det_sync_r[2]) begin
        det_low_r <= det_sync_r[2];
      end
      if (warn_sync_r[1] == warn_sync_r[2]) begin
        warn_low_r <= warn_sync_r[2];
      end
      if (wake_sync_r[1] == wake_sync_r[2]) begin
        wake_prev_r <= wake_sync_r[2];
      end
    end
  end

  logic wake_stable;
  assign wake_stable = (wake_sync_r[1] == wake_sync_r[2]) ? wake_sync_r[2] : wake_prev_r;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode. Zero wait states; unmapped addresses answer with an error.

  logic       wr_en;
  logic       rd_en;
  logic       hit_det;
  logic       hit_warn;
  logic       hit_sts;
  logic       hit_mask;
  logic       lane0;

  assign hit_det  = (paddr_in == `PMSC_DETECT_CTRL_ADDR);
  assign hit_warn = (paddr_in == `PMSC_WARN_STOP_ADDR);
  assign hit_sts  = (paddr_in == `PMSC_IRQ_STATUS_ADDR);
  assign hit_mask = (paddr_in == `PMSC_IRQ_MASK_ADDR);
  assign wr_en    = psel_in && penable_in && pwrite_in;
  assign rd_en    = psel_in && penable_in && !pwrite_in;
  assign lane0    = pstrb_in[0];

  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !(hit_det || hit_warn || hit_sts || hit_mask);

  //////////////////////////////////////////////////////////////////////////////
  // Detect control register.

  logic det_flag_r;
  logic det_irq_en_r;
  logic det_rst_en_r;
  logic det_stop_en_r;
  logic det_master_en_r;
  logic det_wonce_r;
  logic det_wr;
  logic det_active;

  assign det_wr = wr_en && hit_det && lane0;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      det_irq_en_r    <= 1'h0;
      det_rst_en_r    <= 1'h1;
      det_stop_en_r   <= 1'h1;
      det_master_en_r <= 1'h1;
      det_wonce_r     <= 1'h0;
    end else if (det_wr) begin
      det_irq_en_r <= pwdata_in[`PMSC_DET_IRQ_EN_BIT];
      det_stop_en_r <= pwdata_in[`PMSC_DET_STOP_EN_BIT];
      det_master_en_r <= pwdata_in[`PMSC_DET_MASTER_EN_BIT];
      if (!det_wonce_r) begin
        det_rst_en_r <= pwdata_in[`PMSC_DET_RST_EN_BIT];
        det_wonce_r  <= 1'b1;
      end
    end
  end

  // Detection runs when enabled, and in stop only if the stop enable allows it.
  assign det_active = det_master_en_r && (!stop_active_in || det_stop_en_r);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      det_flag_r <= 1'h0;
    end else if (det_active && det_low_r) begin
      det_flag_r <= 1'b1;
    end else if (det_wr && pwdata_in[`PMSC_DET_ACK_BIT]) begin
      det_flag_r <= 1'b0;
    end
  end

  assign detect_on_out    = det_active;
  assign detect_irq_out   = det_flag_r && det_irq_en_r;
  assign detect_reset_out = det_flag_r && det_rst_en_r && det_master_en_r;

  //////////////////////////////////////////////////////////////////////////////
  // Warning and stop control register.

  logic warn_flag_r;
  logic det_trip_r;
  logic warn_trip_r;
  logic ppd_flag_r;
  logic pd_en_r;
  logic pd_sel_r;
  logic pd_wonce_r;
  logic warn_wr;

  assign warn_wr = wr_en && hit_warn && lane0;

  // Trip selects survive every reset except power-on.
  always_ff @(posedge sys_clk_in or posedge por_in) begin
    if (por_in) begin
      det_trip_r  <= 1'h0;
      warn_trip_r <= 1'h0;
    end else if (warn_wr) begin
      det_trip_r  <= pwdata_in[`PMSC_DET_TRIP_BIT];
      warn_trip_r <= pwdata_in[`PMSC_WARN_TRIP_BIT];
    end
  end

  assign detect_trip_select_out  = det_trip_r;
  assign warning_trip_select_out = warn_trip_r;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pd_en_r    <= 1'h0;
      pd_sel_r   <= 1'h0;
      pd_wonce_r <= 1'h0;
    end else if (warn_wr && !pd_wonce_r) begin
      pd_en_r    <= pwdata_in[`PMSC_PD_EN_BIT];
      pd_sel_r   <= pwdata_in[`PMSC_PD_SEL_BIT];
      pd_wonce_r <= 1'b1;
    end
  end

  // The warning flag is set whenever the condition is present, so right after reset too.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      warn_flag_r <= 1'h0;
    end else if (warn_low_r) begin
      warn_flag_r <= 1'b1;
    end else if (warn_wr && pwdata_in[`PMSC_WARN_ACK_BIT]) begin
      warn_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ppd_flag_r <= 1'h0;
    end else if (wake_stable && !wake_prev_r) begin
      ppd_flag_r <= 1'b1;
    end else if (warn_wr && pwdata_in[`PMSC_PPD_ACK_BIT]) begin
      ppd_flag_r <= 1'b0;
    end
  end

  // Stop indication to the stop sequencer.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stop_mode_out <= pmsc_pkg::PMSC_STOP_PLAIN;
    end else if (!stop_req_in || !pd_en_r) begin
      stop_mode_out <= pmsc_pkg::PMSC_STOP_PLAIN;
    end else if (pd_sel_r) begin
      stop_mode_out <= pmsc_pkg::PMSC_STOP_PART_PD;
    end else begin
      stop_mode_out <= pmsc_pkg::PMSC_STOP_FULL_PD;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status (write one to clear, set wins) and mask.

  logic [2:0] irq_sts_r;
  logic [2:0] irq_mask_r;
  logic [2:0] irq_evt;
  logic [2:0] det_flag_d_r;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      det_flag_d_r <= 3'h0;
    end else begin
      det_flag_d_r <= {ppd_flag_r, warn_flag_r, det_flag_r};
    end
  end

  assign irq_evt = {ppd_flag_r, warn_flag_r, detect_irq_out} & ~det_flag_d_r;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_sts_r <= 3'h0;
    end else if (wr_en && hit_sts && lane0) begin
      irq_sts_r <= (irq_sts_r & ~pwdata_in[2:0]) | irq_evt;
    end else begin
      irq_sts_r <= irq_sts_r | irq_evt;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_mask_r <= `PMSC_IRQ_MASK_RST;
    end else if (wr_en && hit_mask && lane0) begin
      irq_mask_r <= pwdata_in[2:0];
    end
  end

  assign irq_out = |(irq_sts_r & irq_mask_r);

  //////////////////////////////////////////////////////////////////////////////
  // Read data; acknowledge bits read as zero.

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out <= 32'h0;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_out <= 32'h0;
      if (paddr_in == `PMSC_DETECT_CTRL_ADDR) begin
        prdata_out[7:0] <= {det_flag_r, 1'b0, det_irq_en_r, det_rst_en_r, det_stop_en_r, det_master_en_r, 2'b00};
      end else if (paddr_in == `PMSC_WARN_STOP_ADDR) begin
        prdata_out[7:0] <= {warn_flag_r, 1'b0, det_trip_r, warn_trip_r, ppd_flag_r, 1'b0, pd_en_r, pd_sel_r};
      end else if (paddr_in == `PMSC_IRQ_STATUS_ADDR) begin
        prdata_out[2:0] <= irq_sts_r;
      end else if (paddr_in == `PMSC_IRQ_MASK_ADDR) begin
        prdata_out[2:0] <= irq_mask_r;
      end
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;

endmodule

// ---- core/pmsc_regs.svh ----
`ifndef PMSC_REGS_SVH
`define PMSC_REGS_SVH

// Byte addresses of the APB registers.
`define PMSC_DETECT_CTRL_ADDR   12'h000
`define PMSC_WARN_STOP_ADDR     12'h004
`define PMSC_IRQ_STATUS_ADDR    12'h008
`define PMSC_IRQ_MASK_ADDR      12'h00c

// Detect control register fields.
`define PMSC_DET_FLAG_BIT       7
`define PMSC_DET_ACK_BIT        6
`define PMSC_DET_IRQ_EN_BIT     5
`define PMSC_DET_RST_EN_BIT     4
`define PMSC_DET_STOP_EN_BIT    3
`define PMSC_DET_MASTER_EN_BIT  2

// Warning and stop control register fields.
`define PMSC_WARN_FLAG_BIT      7
`define PMSC_WARN_ACK_BIT       6
`define PMSC_DET_TRIP_BIT       5
`define PMSC_WARN_TRIP_BIT      4
`define PMSC_PPD_FLAG_BIT       3
`define PMSC_PPD_ACK_BIT        2
`define PMSC_PD_EN_BIT          1
`define PMSC_PD_SEL_BIT         0

// Interrupt status and mask fields.
`define PMSC_IRQ_DET_BIT        0
`define PMSC_IRQ_WARN_BIT       1
`define PMSC_IRQ_PPD_BIT        2

// Reset values.
`define PMSC_DETECT_CTRL_RST    8'h1c
`define PMSC_WARN_STOP_RST      8'h00
`define PMSC_IRQ_MASK_RST       3'h0

`endif

// ---- core/pmsc_pkg.sv ----
package pmsc_pkg;

  typedef enum logic [1:0] {
    PMSC_STOP_PLAIN   = 2'h0,
    PMSC_STOP_FULL_PD = 2'h1,
    PMSC_STOP_PART_PD = 2'h3
  } pmsc_stop_mode_t;

endpackage

// ---- dv/pmsc_top_sva.sv ----
`timescale 1ns/1ns
`include "pmsc_regs.svh"
module pmsc_top_sva (
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic        por_in,
  input wire logic [11:0] paddr_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic        stop_active_in,
  input wire logic        stop_req_in,
  input wire logic        detect_on_out,
  input wire logic        detect_trip_select_out,
  input wire logic        warning_trip_select_out,
  input wire logic        detect_reset_out,
  input wire logic [1:0]  stop_mode_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic wr_dc;
  logic wr_ws;
  assign wr_dc = psel_in && penable_in && pwrite_in && pstrb_in[0] && paddr_in == `PMSC_DETECT_CTRL_ADDR;
  assign wr_ws = psel_in && penable_in && pwrite_in && pstrb_in[0] && paddr_in == `PMSC_WARN_STOP_ADDR;
  property p_trip_wr;
    wr_ws |=> detect_trip_select_out == $past(pwdata_in[5]) && warning_trip_select_out == $past(pwdata_in[4]);
  endproperty
  a_trip_wr: assert property (p_trip_wr) else $error("trip select not loaded");
  property p_det_off;
    wr_dc && !pwdata_in[2] |=> !detect_on_out;
  endproperty
  a_det_off: assert property (p_det_off) else $error("detection on while disabled");
  property p_det_stop;
    wr_dc && pwdata_in[3:2] == 2'b01 && stop_active_in ##1 stop_active_in |-> !detect_on_out;
  endproperty
  a_det_stop: assert property (p_det_stop) else $error("detection on in stop");
  property p_det_run;
    wr_dc && pwdata_in[2] && !stop_active_in ##1 !stop_active_in |-> detect_on_out;
  endproperty
  a_det_run: assert property (p_det_run) else $error("detection off while enabled");
  property p_rst_q;
    detect_reset_out && !stop_active_in |-> detect_on_out;
  endproperty
  a_rst_q: assert property (p_rst_q) else $error("reset request without master enable");
  property p_smode0;
    !stop_req_in |=> stop_mode_out == pmsc_pkg::PMSC_STOP_PLAIN;
  endproperty
  a_smode0: assert property (p_smode0) else $error("stop mode without request");
  property p_smode_ok;
    stop_mode_out != 2'h2;
  endproperty
  a_smode_ok: assert property (p_smode_ok) else $error("illegal stop mode code");
  property p_trip_keep;
    disable iff (por_in) rst_in && $past(rst_in) |-> $stable(detect_trip_select_out) && $stable(warning_trip_select_out);
  endproperty
  a_trip_keep: assert property (p_trip_keep) else $error("trip select lost in reset");
  c_rst: cover property (detect_reset_out);
  c_ppd: cover property (stop_mode_out == pmsc_pkg::PMSC_STOP_PART_PD);
  c_ws: cover property (wr_ws);
endmodule

// ---- dv/pmsc_top_tb_top.sv ----
`timescale 1ns/1ns
`include "pmsc_regs.svh"
module pmsc_top_tb_top;
  localparam logic [11:0] AD = `PMSC_DETECT_CTRL_ADDR;
  localparam logic [11:0] AW = `PMSC_WARN_STOP_ADDR;
  localparam logic [11:0] AS = `PMSC_IRQ_STATUS_ADDR;
  localparam logic [11:0] AM = `PMSC_IRQ_MASK_ADDR;
  logic        clk = 1'b0, rst = 1'b1, por = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        dlow = 1'b0, wlow = 1'b0, wake = 1'b0, sreq = 1'b0, sact = 1'b0;
  logic        prdy, perr, don, dts, wts, dirq, drst, irq;
  logic [11:0] pa = 12'h0;
  logic [31:0] pwd = 32'h0, prd, t;
  logic [1:0]  smode;
  logic [31:0] q[$];
  int          errors = 0, n_compared = 0;
  always #4 clk = ~clk;
  pmsc_top u_dut (.sys_clk_in(clk), .rst_in(rst), .por_in(por), .paddr_in(pa), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwd), .pstrb_in(4'hf), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .detect_low_in(dlow), .warning_low_in(wlow),
    .stop_active_in(sact), .ppd_wake_in(wake), .stop_req_in(sreq), .detect_on_out(don),
    .detect_trip_select_out(dts), .warning_trip_select_out(wts), .detect_irq_out(dirq),
    .detect_reset_out(drst), .stop_mode_out(smode), .irq_out(irq));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_of_test;
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pa <= a;
    pwr <= w;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic rstp(input logic p, input int n);
    @(posedge clk);
    rst <= 1'b1;
    por <= p;
    cyc(n);
    @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    cyc(1);
  endtask
  always @(posedge clk) begin
    if (psel && pen && !pwr && prdy === 1'b1) begin
      chk(prd, q.pop_front());
    end
  end
  initial begin
    void'($urandom(59196));
    t = $urandom & 32'h30;
    rstp(1'b1, 16);
    rd(AD, 32'h1c);
    rd(AW, 32'h0);
    apb(AD, 1'b1, 32'h24);
    rd(AD, 32'h24);
    apb(AD, 1'b1, 32'h3c);
    rd(AD, 32'h2c);
    @(posedge clk) dlow <= 1'b1;
    cyc(8);
    rd(AD, 32'hac);
    chk({31'h0, dirq}, 32'h1);
    chk({31'h0, drst}, 32'h0);
    rd(AS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(AM, 1'b1, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(AS, 1'b1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk) dlow <= 1'b0;
    cyc(8);
    apb(AD, 1'b1, 32'h6c);
    rd(AD, 32'h2c);
    chk({31'h0, dirq}, 32'h0);
    apb(AD, 1'b1, 32'h20);
    chk({31'h0, don}, 32'h0);
    @(posedge clk) dlow <= 1'b1;
    cyc(8);
    rd(AD, 32'h20);
    @(posedge clk) dlow <= 1'b0;
    cyc(8);
    @(posedge clk) sact <= 1'b1;
    apb(AD, 1'b1, 32'h24);
    chk({31'h0, don}, 32'h0);
    apb(AD, 1'b1, 32'h2c);
    chk({31'h0, don}, 32'h1);
    @(posedge clk) sact <= 1'b0;
    apb(AW, 1'b1, t | 32'h3);
    rd(AW, t | 32'h3);
    chk({30'h0, dts, wts}, t >> 4);
    apb(AW, 1'b1, t);
    rd(AW, t | 32'h3);
    @(posedge clk) sreq <= 1'b1;
    cyc(3);
    chk({30'h0, smode}, 32'h3);
    @(posedge clk) sreq <= 1'b0;
    wlow <= 1'b1;
    cyc(8);
    rd(AW, t | 32'h83);
    apb(AW, 1'b1, t | 32'h40);
    rd(AW, t | 32'h83);
    @(posedge clk) wlow <= 1'b0;
    cyc(8);
    apb(AW, 1'b1, t | 32'h40);
    rd(AW, t | 32'h3);
    @(posedge clk) wake <= 1'b1;
    cyc(8);
    rd(AW, t | 32'hb);
    apb(AW, 1'b1, t | 32'h4);
    rd(AW, t | 32'h3);
    @(posedge clk) wake <= 1'b0;
    rd(12'h010, 32'h0);
    rstp(1'b0, 2);
    rd(AW, t);
    @(posedge clk) sreq <= 1'b1;
    cyc(3);
    chk({30'h0, smode}, 32'h0);
    @(posedge clk) sreq <= 1'b0;
    dlow <= 1'b1;
    cyc(8);
    chk({31'h0, drst}, 32'h1);
    @(posedge clk) dlow <= 1'b0;
    rstp(1'b1, 2);
    rd(AW, 32'h0);
    end_of_test;
  end
  initial begin
    cyc(5000);
    errors++;
    end_of_test;
  end
endmodule
bind pmsc_top pmsc_top_sva u_sva (.*);
